//--- pkg/sii_pkg.sv
// Shared constants and types of the serial instruction injector
package sii_pkg;

    localparam int unsigned CODE_W        = 4;
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned CNT_W         = 5;
    localparam int unsigned FETCH_CLKS    = 4;
    localparam int unsigned SHIFT_CLKS    = 16;
    localparam int unsigned TW_HEAD_CLKS  = 4;
    localparam int unsigned TW_TAIL_CLKS  = 12;
    localparam int unsigned RD_EXEC_CLKS  = 8;
    localparam int unsigned RD_OUT_CLKS   = 8;
    localparam int unsigned CODE_MSB      = 15;
    localparam int unsigned CODE_LSB      = 12;
    localparam logic [1:0]  CLASS_READ    = 2'h2;
    localparam logic [1:0]  CLASS_WRITE   = 2'h3;
    localparam logic [3:0]  CODE_NOP      = 4'h0;
    localparam logic [15:0] SHIFT_RST     = 16'h0000;
    localparam logic [7:0]  LATCH_RST     = 8'h00;

    typedef enum logic [6:0] {
        ST_FETCH = 7'h01,
        ST_SHIFT = 7'h02,
        ST_TWA   = 7'h04,
        ST_TWB   = 7'h08,
        ST_TRX   = 7'h10,
        ST_TRO   = 7'h20,
        ST_PRE   = 7'h40
    } sii_state_e;

    typedef enum logic [2:0] {
        K_NONE    = 3'h0,
        K_INSTR   = 3'h1,
        K_SECOND  = 3'h2,
        K_OPERAND = 3'h3,
        K_TABLE_READ_OP   = 3'h4,
        K_TW1     = 3'h5,
        K_TW2     = 3'h6
    } sii_kind_e;

    typedef struct packed {
        sii_kind_e   kind;
        logic [1:0]  ptr_mode;
        logic [15:0] word;
    } sii_cmd_s;

    localparam sii_cmd_s CMD_RST = '{kind: K_NONE, ptr_mode: 2'h0, word: 16'h0000};

endpackage : sii_pkg

//--- logic/sii_pin_sync.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module sii_pin_sync #(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] fall_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;

    // Refused at elaboration: a zero-width synchroniser serves nothing
    if (WIDTH < 1)
    begin : g_width_check
        $error("sii_pin_sync needs at least one bit");
    end

    // The meta stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~prev_reg;
    assign fall_o  = ~sync_reg & prev_reg;

endmodule : sii_pin_sync

//--- logic/sii_core.sv
// Serial execution state machine of the programming port
`timescale 1ns/1ps
// Contract
// RL1: Fetched no-op: hold CPU, shift sixteen bits
// RL2: During that shift CPU frozen in fourth_phase
// RL3: Two-cycle first cycle runs during next fetch
// RL4: Programmer sends no-op after two-cycle instruction
// RL5: One-word second half: discard word, then release
// RL6: Two-word second half: word is operand
// RL7: Table writes are 4-bit special codes
// RL8: Code fetched while previous instruction executes
// RL9: Write: first cycle over four bits, twelve more
// RL10: Write word used in second cycle only
// RL11: Programmer holds clock high for pulse time
// RL12: Programming stops when clock goes low
// RL13: Programmer holds clock low for discharge
// RL14: Read runs CPU eight clocks, loads latch
// RL15: Then eight clocks shifting latch out, LSB first
// RL16: After read, suspend CPU for code prefetch
// RL17: Programmer builds commands from CPU instructions
// RL18: No separate data-load command exists
// RL19: Address advances via auto-increment table writes
// RL20: Programming ends when write execution ends
// RL21: Entry by high voltage, clock/data low
// RL22: Data changes on rise, sampled on fall
// RL23: Codes: 0000 nop, 10xx read, 11xx write
// RL24: Undefined special codes act as no-op
// RL25: Data pin released after eighth read bit
module sii_core
    import sii_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        MODE_ENTRY_HV_PIN_I,
    input  wire logic        PROG_CLOCK_PIN_I,
    input  wire logic        PROG_DATA_PIN_I,
    output logic             PROG_DATA_PIN_O,
    output logic             PROG_DATA_PIN_OE_N_O,
    input  wire logic        CPU_TWO_CYCLE_I,
    input  wire logic        CPU_TWO_WORD_I,
    input  wire logic [7:0]  TABLE_LATCH_I,
    output sii_pkg::sii_cmd_s CMD_O,
    output logic             CMD_VALID_O,
    output logic             CPU_RUN_O,
    output logic             CPU_HOLD_Q4_O,
    output logic             PROGRAM_PULSE_O
);
    import sii_pkg::*;

    logic             rst_meta_reg;
    logic             rst_n;
    logic [2:0]       pin_level;
    logic [2:0]       pin_rise;
    logic [2:0]       pin_fall;
    logic             in_mode;
    logic             clk_high;
    logic             rise;
    logic             fall;
    logic             din;
    sii_state_e       state_reg;
    sii_state_e       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic             done;
    logic [15:0]      shift_reg;
    logic [7:0]       out_reg;
    logic             oe_n_reg;
    logic             forced_noop_reg;
    logic             pend_reg;
    logic             pend_word_reg;
    logic             prog_arm_reg;
    logic             prog_pulse_reg;
    sii_cmd_s         cmd_reg;
    logic             cmd_valid_reg;
    logic [3:0]       code;

    // Reset arrives asynchronously but leaves only on a clock edge
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    sii_pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk_i   (CLK_I),
        .rst_n_i (rst_n),
        .pin_i   ({MODE_ENTRY_HV_PIN_I, PROG_DATA_PIN_I, PROG_CLOCK_PIN_I}),
        .level_o (pin_level),
        .rise_o  (pin_rise),
        .fall_o  (pin_fall)
    );

    assign in_mode  = pin_level[2];
    assign din      = pin_level[1];
    assign clk_high = pin_level[0];
    assign rise     = pin_rise[0] & in_mode;
    assign fall     = pin_fall[0] & in_mode;
    // The last code bit is still on the wire at the closing fall
    assign code     = {din, shift_reg[CODE_MSB:CODE_LSB+1]};

    function automatic logic [CNT_W-1:0] clks_of(input sii_state_e st);
        case (st)
            ST_SHIFT: clks_of = CNT_W'(SHIFT_CLKS);
            ST_TWA:   clks_of = CNT_W'(TW_HEAD_CLKS);
            ST_TWB:   clks_of = CNT_W'(TW_TAIL_CLKS);
            ST_TRX:   clks_of = CNT_W'(RD_EXEC_CLKS);
            ST_TRO:   clks_of = CNT_W'(RD_OUT_CLKS);
            default:  clks_of = CNT_W'(FETCH_CLKS);
        endcase
    endfunction : clks_of

    // Special code decode; anything unknown goes the no-op way
    function automatic sii_state_e decode(input logic [3:0] c);
        case (c[3:2])
            CLASS_WRITE: decode = ST_TWA; // RL7 RL23
            CLASS_READ:  decode = ST_TRX; // RL23
            default:     decode = ST_SHIFT; // RL23 RL24
        endcase
    endfunction : decode

    // Every phase is counted in falling serial clock edges
    assign done = fall && (cnt_reg == clks_of(state_reg) - CNT_W'(1)); // RL22

    always_comb
    begin
        state_next = state_reg;
        if (done)
        begin
            case (state_reg)
                ST_FETCH: state_next = decode(code); // RL8
                ST_PRE:   state_next = decode(code); // RL16
                ST_SHIFT: state_next = ST_FETCH; // RL1
                ST_TWA:   state_next = ST_TWB; // RL9
                ST_TWB:   state_next = ST_FETCH; // RL10
                ST_TRX:   state_next = ST_TRO; // RL15
                ST_TRO:   state_next = ST_PRE; // RL16 RL25
                default:  state_next = ST_FETCH;
            endcase
        end
    end

    // Leaving the high-voltage mode acts as a reset of the sequencer
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= ST_FETCH;
        else if (!in_mode)
            state_reg <= ST_FETCH;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            cnt_reg <= '0;
        else if (!in_mode || done)
            cnt_reg <= '0;
        else if (fall)
            cnt_reg <= cnt_reg + CNT_W'(1);
    end

    // Bits arrive LSB first, so they enter at the top and move down
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            shift_reg <= SHIFT_RST;
        else if (fall && state_reg != ST_TRO)
            shift_reg <= {din, shift_reg[15:1]}; // RL22
    end

    // First instruction after entry is a forced no-op
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            forced_noop_reg <= 1'b1;
        else if (!in_mode)
            forced_noop_reg <= 1'b1;
        else if (done)
            forced_noop_reg <= 1'b0; // RL8
    end

    // Second half of a two-cycle instruction still owed
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_reg      <= 1'b0;
            pend_word_reg <= 1'b0;
        end
        else if (!in_mode)
        begin
            pend_reg      <= 1'b0;
            pend_word_reg <= 1'b0;
        end
        else if (cmd_valid_reg && cmd_reg.kind == K_INSTR)
        begin
            pend_reg      <= CPU_TWO_CYCLE_I; // RL3
            pend_word_reg <= CPU_TWO_WORD_I;
        end
        else if (cmd_valid_reg && cmd_reg.kind inside {K_SECOND, K_OPERAND, K_TABLE_READ_OP, K_TW1})
        begin
            pend_reg      <= 1'b0;
            pend_word_reg <= 1'b0;
        end
    end

    // Commands to the CPU, at most one pulse per transition
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_reg       <= CMD_RST;
            cmd_valid_reg <= 1'b0;
        end
        else
        begin
            cmd_valid_reg <= 1'b0;
            if (done && in_mode)
            begin
                case (state_reg)
                    ST_SHIFT:
                    begin
                        cmd_valid_reg     <= 1'b1;
                        cmd_reg.ptr_mode  <= 2'h0;
                        if (!pend_reg)
                        begin
                            cmd_reg.kind <= K_INSTR; // RL1
                            cmd_reg.word <= {din, shift_reg[15:1]};
                        end
                        else if (pend_word_reg)
                        begin
                            cmd_reg.kind <= K_OPERAND; // RL6
                            cmd_reg.word <= {din, shift_reg[15:1]};
                        end
                        else
                        begin
                            cmd_reg.kind <= K_SECOND; // RL5
                            cmd_reg.word <= 16'h0000;
                        end
                    end
                    ST_FETCH, ST_PRE:
                    begin
                        cmd_reg.ptr_mode <= code[1:0];
                        cmd_reg.word     <= 16'h0000;
                        if (code[3:2] == CLASS_WRITE)
                        begin
                            cmd_valid_reg <= 1'b1;
                            cmd_reg.kind  <= K_TW1; // RL9
                        end
                        else if (code[3:2] == CLASS_READ)
                        begin
                            cmd_valid_reg <= 1'b1;
                            cmd_reg.kind  <= K_TABLE_READ_OP; // RL14
                        end
                    end
                    ST_TWB:
                    begin
                        cmd_valid_reg <= 1'b1;
                        cmd_reg.kind  <= K_TW2; // RL10
                        cmd_reg.word  <= {din, shift_reg[15:1]};
                    end
                    default:
                    begin
                        cmd_valid_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Pulse follows the serial clock; the first fall ends it for good
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_arm_reg   <= 1'b0;
            prog_pulse_reg <= 1'b0;
        end
        else
        begin
            // Arming happens on a fall itself, so it must win over the clear
            if (!in_mode)
                prog_arm_reg <= 1'b0;
            else if (state_reg == ST_TWB && done)
                prog_arm_reg <= 1'b1; // RL10
            else if (fall)
                prog_arm_reg <= 1'b0; // RL12 RL20
            prog_pulse_reg <= prog_arm_reg && clk_high && !fall; // RL12
        end
    end

    // Readout drives the pin; bits change on rising edges
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_reg  <= LATCH_RST;
            oe_n_reg <= 1'b1;
        end
        else if (!in_mode)
        begin
            oe_n_reg <= 1'b1;
        end
        else if (state_reg == ST_TRX && done)
        begin
            out_reg  <= TABLE_LATCH_I; // RL14
            oe_n_reg <= 1'b0; // RL15
        end
        else if (state_reg == ST_TRO && done)
        begin
            oe_n_reg <= 1'b1; // RL25
        end
        else if (state_reg == ST_TRO && rise && cnt_reg != '0)
        begin
            out_reg <= {1'b0, out_reg[7:1]}; // RL15 RL22
        end
    end

    assign CMD_O                = cmd_reg;
    assign CMD_VALID_O          = cmd_valid_reg;
    assign PROG_DATA_PIN_O      = out_reg[0];
    assign PROG_DATA_PIN_OE_N_O = oe_n_reg;
    assign PROGRAM_PULSE_O      = prog_pulse_reg;
    // CPU runs only in execute slots; the forced no-op keeps it idle
    assign CPU_RUN_O     = in_mode && ((state_reg == ST_FETCH && !forced_noop_reg) || // RL3
                           state_reg == ST_TWA || state_reg == ST_TRX); // RL9 RL14
    assign CPU_HOLD_Q4_O = in_mode && !CPU_RUN_O; // RL2 RL16

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    a_nop_freeze: assert property (in_mode && state_reg == ST_SHIFT |-> CPU_HOLD_Q4_O && !CPU_RUN_O) // RL2
        else $error("CPU not frozen during instruction shift");
    a_shift_issue: assert property (in_mode && state_reg == ST_SHIFT && done
        |=> state_reg == ST_FETCH && CMD_VALID_O && CMD_O.kind inside {K_INSTR, K_SECOND, K_OPERAND}) // RL1
        else $error("Shifted word not issued after sixteen clocks");
    a_fetch_runs: assert property (in_mode && state_reg == ST_FETCH && !forced_noop_reg |-> CPU_RUN_O) // RL3
        else $error("CPU idle during execute slot");
    a_tw_split: assert property (in_mode && state_reg == ST_TWA && done
        |=> state_reg == ST_TWB && cnt_reg == '0 && !CPU_RUN_O) // RL9
        else $error("Write head phase wrong");
    a_tw_data: assert property (in_mode && state_reg == ST_TWB && done
        |=> CMD_VALID_O && CMD_O.kind == K_TW2 && prog_arm_reg) // RL10
        else $error("Write word not issued");
    a_prog_stop: assert property (prog_arm_reg && fall |=> !prog_arm_reg ##1 !PROGRAM_PULSE_O) // RL12
        else $error("Programming pulse outlived clock fall");
    a_rd_drive: assert property (in_mode && state_reg == ST_TRO |-> !PROG_DATA_PIN_OE_N_O) // RL15
        else $error("Data pin not driven during readout");
    a_rd_release: assert property (in_mode && state_reg == ST_TRO && done
        |=> PROG_DATA_PIN_OE_N_O && state_reg == ST_PRE && !CPU_RUN_O) // RL25
        else $error("Data pin not released after readout");
    a_rd_decode: assert property (in_mode && state_reg inside {ST_FETCH, ST_PRE} && done
        && code[3:2] == CLASS_READ |=> state_reg == ST_TRX && CPU_RUN_O) // RL23
        else $error("Read code not decoded");
    a_undef_nop: assert property (in_mode && state_reg == ST_FETCH && done && !code[3]
        |=> state_reg == ST_SHIFT) // RL24
        else $error("Undefined code not treated as no-op");

    c_instr: cover property (CMD_VALID_O && CMD_O.kind == K_INSTR);
    c_operand: cover property (CMD_VALID_O && CMD_O.kind == K_OPERAND);
    c_write: cover property (PROGRAM_PULSE_O);
    c_read: cover property (state_reg == ST_TRO ##[1:400] state_reg == ST_PRE);

endmodule : sii_core

//--- verification/sii_prog_model.sv
// Behavioural model of the external device programmer
`timescale 1ns/1ps
module sii_prog_model #(
    parameter int PULSE_NS = 1000,
    parameter int DISCH_NS = 500
) (
    input  wire logic line_i,
    output logic      clk_o,
    output logic      data_o,
    output logic      hv_o
);
    initial
    begin
        clk_o = 1'b0;
        data_o = 1'b0;
        hv_o = 1'b0;
    end

    // Clock and data are already low when the high level arrives
    task automatic enter;
        hv_o = 1'b1;
    endtask : enter

    // Dropping the high level resets the device sequencer
    task automatic leave;
        hv_o = 1'b0;
    endtask : leave

    // Data moves with the rising edge, the device takes it at the fall
    task automatic bit_out(input logic b);
        clk_o = 1'b1;
        data_o = b;
        #100;
        clk_o = 1'b0;
        #100;
    endtask : bit_out

    // Released line shows a changing level so a stale bit cannot pass
    task automatic read_bit(output logic b);
        clk_o = 1'b1;
        data_o = ~data_o;
        #100;
        clk_o = 1'b0;
        #50;
        b = line_i;
        #50;
    endtask : read_bit

    // Clock held high for the pulse, then low while the array discharges
    task automatic pulse_bit(input logic b);
        clk_o = 1'b1;
        data_o = b;
        #(PULSE_NS);
        clk_o = 1'b0;
        #(DISCH_NS);
    endtask : pulse_bit
endmodule : sii_prog_model

//--- verification/tb.sv
// Self-checking bench of the serial instruction injector
`timescale 1ns/1ps
module tb;
    import sii_pkg::*;
    localparam int PULSE_NS = 1000;
    logic          clk;
    logic          rst_n;
    logic          hv;
    logic          pclk;
    logic          mdata;
    logic          pin;
    logic          dout;
    logic          oe_n;
    logic          two_cyc;
    logic          two_wrd;
    logic [7:0]    latch;
    sii_cmd_s      cmd;
    logic          cmd_valid;
    logic          run;
    logic          hold;
    logic          pulse;
    sii_cmd_s      cmd_q[$];
    int            fail_count;
    int            samples_checked;
    integer        seed;
    logic [31:0]   r;

    sii_core sii_core_inst (
        .CLK_I                (clk),
        .RESET_N_I            (rst_n),
        .MODE_ENTRY_HV_PIN_I  (hv),
        .PROG_CLOCK_PIN_I     (pclk),
        .PROG_DATA_PIN_I      (pin),
        .PROG_DATA_PIN_O      (dout),
        .PROG_DATA_PIN_OE_N_O (oe_n),
        .CPU_TWO_CYCLE_I      (two_cyc),
        .CPU_TWO_WORD_I       (two_wrd),
        .TABLE_LATCH_I        (latch),
        .CMD_O                (cmd),
        .CMD_VALID_O          (cmd_valid),
        .CPU_RUN_O            (run),
        .CPU_HOLD_Q4_O        (hold),
        .PROGRAM_PULSE_O      (pulse)
    );

    sii_prog_model #(.PULSE_NS(PULSE_NS), .DISCH_NS(500)) sii_prog_model_inst (
        .line_i (pin),
        .clk_o  (pclk),
        .data_o (mdata),
        .hv_o   (hv)
    );

    // The device wins the line only while its enable is low
    assign pin = (oe_n === 1'b0) ? dout : mdata;

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Sampled mid-cycle so the one-cycle pulse is settled
    always @(negedge clk)
        if (cmd_valid === 1'b1)
            cmd_q.push_back(cmd);

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic exp_cmd(input sii_kind_e k, input logic [1:0] pm, input logic [15:0] w, input logic [20:0] m);
        int       n;
        sii_cmd_s got;
        n = 0;
        while (cmd_q.size() == 0 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        if (cmd_q.size() == 0)
        begin
            fail_count++;
            $display("MISMATCH %0t no command seen", $time);
            finish_test();
        end
        else
        begin
            got = cmd_q.pop_front();
            check(32'(got & m), 32'({k, pm, w} & m), "command");
        end
    endtask : exp_cmd

    task automatic send_code(input logic [3:0] c);
        for (int i = 0; i < 4; i++)
            sii_prog_model_inst.bit_out(c[i]);
    endtask : send_code

    task automatic send_word(input logic [15:0] w, input logic wr);
        for (int i = 0; i < 16; i++)
        begin
            if (i == 2 && wr)
                check(32'(run), 32'h1, "run in write head");
            if (i == 8 && !wr)
                check(32'({run, hold}), 32'h1, "held while shifting");
            sii_prog_model_inst.bit_out(w[i]);
        end
    endtask : send_word

    // Word shifted after a no-op, then executed while the next code comes
    task automatic nop_tail(input logic [15:0] w);
        two_cyc = 1'b0;
        two_wrd = 1'b0;
        send_word(w, 1'b0);
        exp_cmd(K_INSTR, 2'h0, w, 21'h1cffff);
        check(32'(run), 32'h1, "run after shift");
    endtask : nop_tail

    task automatic run_code(input logic [3:0] c, input logic [15:0] w);
        logic [7:0] got;
        logic       b;
        latch = w[7:0];
        send_code(c);
        if (c[3:2] == CLASS_READ)
        begin
            exp_cmd(K_TABLE_READ_OP, c[1:0], 16'h0000, 21'h1f0000);
            for (int i = 0; i < 8; i++)
            begin
                if (i == 4)
                    check(32'({oe_n, run}), 32'h3, "read exec");
                sii_prog_model_inst.bit_out(1'b0);
            end
            for (int i = 0; i < 8; i++)
            begin
                if (i == 4)
                    check(32'({oe_n, run}), 32'h0, "readout");
                sii_prog_model_inst.read_bit(b);
                got[i] = b;
            end
            check(32'(got), 32'(latch), "read byte");
            repeat (4) @(negedge clk);
            check(32'({oe_n, hold, run}), 32'h6, "after readout");
        end
        else if (c[3:2] == CLASS_WRITE)
        begin
            exp_cmd(K_TW1, c[1:0], 16'h0000, 21'h1f0000);
            send_word(w, 1'b1);
            exp_cmd(K_TW2, c[1:0], w, 21'h1fffff);
            fork
                sii_prog_model_inst.pulse_bit(1'b0);
                begin
                    #500;
                    check(32'(pulse), 32'h1, "pulse on");
                    #(PULSE_NS + 150 - 500);
                    check(32'(pulse), 32'h0, "pulse off");
                end
            join
            for (int i = 0; i < 3; i++)
                sii_prog_model_inst.bit_out(1'b0);
            nop_tail(~w);
        end
        else
            nop_tail(w);
    endtask : run_code

    task automatic two_cycle(input logic tw);
        logic [31:0] v;
        v = $random(seed);
        two_cyc = 1'b1;
        two_wrd = tw;
        send_code(CODE_NOP);
        send_word(v[15:0], 1'b0);
        exp_cmd(K_INSTR, 2'h0, v[15:0], 21'h1cffff);
        for (int i = 0; i < 4; i++)
        begin
            if (i == 2)
                check(32'(run), 32'h1, "first cycle runs");
            sii_prog_model_inst.bit_out(1'b0);
        end
        send_word(v[31:16], 1'b0);
        exp_cmd(tw ? K_OPERAND : K_SECOND, 2'h0, tw ? v[31:16] : 16'h0000, 21'h1cffff);
        check(32'(run), 32'h1, "second cycle runs");
        two_cyc = 1'b0;
    endtask : two_cycle

    initial
    begin
        #2000000;
        fail_count++;
        $display("MISMATCH %0t run did not finish", $time);
        finish_test();
    end

    initial
    begin
        fail_count = 0;
        samples_checked = 0;
        seed = 32'h9c9c;
        rst_n = 1'b0;
        two_cyc = 1'b0;
        two_wrd = 1'b0;
        latch = 8'h00;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        sii_prog_model_inst.enter();
        repeat (10) @(negedge clk);
        // Every code once, starting straight after the forced no-op
        for (int c = 0; c < 16; c++)
        begin
            r = $random(seed);
            run_code(4'(c), r[15:0]);
        end
        $display("all special codes done");
        two_cycle(1'b0);
        two_cycle(1'b1);
        $display("two-cycle instructions done");
        // Leaving the mode halfway through a code restarts at the forced no-op
        sii_prog_model_inst.bit_out(1'b0);
        sii_prog_model_inst.bit_out(1'b0);
        sii_prog_model_inst.leave();
        repeat (10) @(negedge clk);
        check(32'({oe_n, hold, run}), 32'h4, "mode left");
        sii_prog_model_inst.enter();
        repeat (10) @(negedge clk);
        check(32'({oe_n, hold, run}), 32'h6, "forced no-op again");
        r = $random(seed);
        run_code(4'hc, r[15:0]);
        $display("mode exit done");
        repeat (12)
        begin
            r = $random(seed);
            run_code(r[3:0], r[31:16]);
        end
        $display("random codes done");
        finish_test();
    end
endmodule : tb
